// ===== ptcs_pkg.sv
// package of the pulse-per-second timestamp clock unit: map, fields, constants
// assumes a 25 MHz core clock and a 32-bit plain register port
package ptcs_pkg;

  // ==========================================================
  // timing
  localparam logic [31:0] CLK_NS     = 32'h0000_0028;  // clock period, 40 ns
  localparam logic [31:0] SEC_NS     = 32'h3B9A_CA00;  // one second in ns
  localparam logic [31:0] HALF_NS    = 32'h1DCD_6500;  // half a second in ns
  localparam logic [31:0] PULSE_NS   = 32'h05F5_E100;  // internal pulse width, 100 ms
  localparam logic [31:0] THRESH_RST = 32'h0000_0254;  // health threshold default, 596 ns

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;  // selectors
  localparam logic [7:0] OFS_THRESH   = 8'h04;  // health threshold ns
  localparam logic [7:0] OFS_HOST_SEC = 8'h08;  // host seconds, write ticks overflow source
  localparam logic [7:0] OFS_HOST_NS  = 8'h0C;  // host nanoseconds
  localparam logic [7:0] OFS_CMD      = 8'h10;  // commands, write only
  localparam logic [7:0] OFS_STATUS   = 8'h14;  // sync status
  localparam logic [7:0] OFS_TIME_SEC = 8'h18;  // clock seconds
  localparam logic [7:0] OFS_TIME_NS  = 8'h1C;  // clock nanoseconds
  localparam logic [7:0] OFS_TOTAL    = 8'h20;  // pulses received
  localparam logic [7:0] OFS_BAD      = 8'h24;  // bad pulses
  localparam logic [7:0] OFS_SINGLES  = 8'h28;  // missed pulses
  localparam logic [7:0] OFS_LONGEST  = 8'h2C;  // longest missed run
  localparam logic [7:0] OFS_FAIL     = 8'h30;  // failures
  localparam logic [7:0] OFS_RESYNC   = 8'h34;  // resyncs
  localparam logic [7:0] OFS_FREQ     = 8'h38;  // frequency error ppb
  localparam logic [7:0] OFS_PHASE    = 8'h3C;  // phase error ns
  localparam logic [7:0] OFS_WFREQ    = 8'h40;  // worst frequency error
  localparam logic [7:0] OFS_WPHASE   = 8'h44;  // worst phase error

  // ==========================================================
  // field positions
  localparam int CTRL_IN_LSB  = 0;  // input selector, 2 bits
  localparam int CTRL_OUT_LSB = 2;  // output selector, 2 bits
  localparam int CMD_SET      = 0;  // load host time
  localparam int CMD_RESET    = 1;  // full clock reset
  localparam int CMD_CLEAR    = 2;  // clear statistics

  // ==========================================================
  // selector modes
  typedef enum logic [1:0] {IN_NONE, IN_SERIAL, IN_OVER} ptcs_in_t;
  typedef enum logic [1:0] {OUT_NONE, OUT_REPEAT, OUT_LOOP, OUT_MASTER} ptcs_out_t;

  // register port carrier
  typedef struct packed {
    logic [7:0]  addr;   // byte address
    logic [31:0] wdata;  // write data
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } ptcs_bus_t;

  // whole state of the unit
  typedef struct packed {
    ptcs_in_t    in_sel;     // discipline source
    ptcs_out_t   out_sel;    // output source
    logic [31:0] thresh;     // health threshold
    logic [31:0] host_sec;   // host time seconds
    logic [29:0] host_ns;    // host time ns
    logic [31:0] sec;        // clock seconds
    logic [29:0] ns;         // clock ns
    logic        synced;     // synchronised flag
    logic        pulse_d;    // previous serial input
    logic        have_ref;   // a reference has been seen
    logic [31:0] since;      // cycles since last reference
    logic [31:0] total;      // statistics
    logic [31:0] bad;
    logic [31:0] singles;
    logic [31:0] longest;
    logic [31:0] run;
    logic [31:0] fail;
    logic [31:0] resync;
    logic [31:0] freq_err;   // signed ppb
    logic [31:0] phase_err;  // signed ns
    logic [31:0] worst_f;
    logic [31:0] worst_p;
    logic [31:0] rdata;      // read data
    logic        sync_out;   // pulse output
    logic        sync_oe_n;  // output enable, low drives
  } ptcs_state_t;

endpackage

// ===== ptcs_pulse_src.sv
// far side of the pulse link: a time receiver or a peer card sending one pulse per call
// assumes the caller invokes emit right after a rising clock edge
`timescale 1ns/1ns
module ptcs_pulse_src
#(
  parameter int WIDTH = 10  // pulse high time in cycles, arbitrary
)
(
  input  wire logic i_clock,
  output logic      o_pulse
);
  // ==========================================================
  // pulse generation
  // the line idles low and is always driven, never left floating
  initial o_pulse = 1'b0;

  // one rising edge now, the next call rises gap cycles later
  task automatic emit(input int gap);
    o_pulse <= 1'b1;
    repeat (WIDTH) @(posedge i_clock);
    o_pulse <= 1'b0;
    repeat (gap - WIDTH) @(posedge i_clock);
  endtask
endmodule

// ===== ptcs_top.sv
// pulse-per-second timestamp clock synchroniser: register port, clock, discipline, statistics
// assumes i_pulse already received from the differential line and synchronous to i_clock
//
// Overview of operation
// - clock loads host time, then free-runs
// - serial pulse input disciplines the clock
// - default: serial input, output off
// - overflow source tracks host seconds writes
// - repeat setting echoes serial pulse out
// - loop setting outputs serial input, or internal pulse for overflow
// - master setting outputs internal pulse
// - programmable threshold, default 596 ns
// - set loads host time, selectors kept
// - reset loads time, serial in, off
// - no input: free run, not synchronised
// - host-disciplined card can drive slave
// - pulse, miss, failure counts; clearable
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module ptcs_top
  import ptcs_pkg::*;
#(
  parameter logic [31:0] CYC_SEC  = SEC_NS / CLK_NS,      // cycles per second
  parameter logic [31:0] MIN_GAP  = CYC_SEC / 32'h2,      // shorter gap is a bad pulse
  parameter logic [31:0] MISS_GAP = CYC_SEC + MIN_GAP     // longer gap is a missed pulse
)
(
  input  wire logic                i_clock,
  input  wire logic                i_resetn,
  input  wire ptcs_pkg::ptcs_bus_t i_bus,
  input  wire logic                i_pulse,
  output logic [31:0]              o_rdata,
  output logic                     o_sync_out,
  output logic                     o_sync_oe_n,
  output logic                     o_synced
);
  import ptcs_pkg::*;

  // ==========================================================
  // state and helpers
  ptcs_state_t st_reg;     // registered state
  ptcs_state_t st_next;    // next state
  logic        wr_ctrl;    // write decodes
  logic        wr_cmd;
  logic        do_set;     // load host time
  logic        do_reset;   // full reset command
  logic        do_clear;   // clear statistics
  logic        tick_over;  // overflow source tick
  logic        ref_edge;   // selected reference edge
  logic        accept;     // reference accepted
  logic        missed;     // reference missed
  logic        int_pulse;  // internal pulse level
  logic [31:0] err;        // phase error at reference
  logic [31:0] err_abs;    // its magnitude
  logic [31:0] ferr;       // frequency error at reference
  logic [31:0] ferr_abs;   // its magnitude
  logic [31:0] ns_inc;     // ns after one clock

  // magnitude of a signed word
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'h0 - v : v;
  endfunction

  // ==========================================================
  // command and event decode
  assign wr_ctrl   = i_bus.wr && (i_bus.addr == OFS_CTRL);
  assign wr_cmd    = i_bus.wr && (i_bus.addr == OFS_CMD);
  assign do_set    = wr_cmd && i_bus.wdata[CMD_SET];
  assign do_reset  = wr_cmd && i_bus.wdata[CMD_RESET];
  assign do_clear  = wr_cmd && i_bus.wdata[CMD_CLEAR];
  // a host seconds write is the overflow tick
  assign tick_over = i_bus.wr && (i_bus.addr == OFS_HOST_SEC);
  assign int_pulse = {2'b00, st_reg.ns} < PULSE_NS;

  // selected reference edge
  always_comb
  begin
    case (st_reg.in_sel)
      IN_SERIAL: ref_edge = i_pulse && !st_reg.pulse_d;
      IN_OVER:   ref_edge = tick_over;
      default:   ref_edge = 1'b0;
    endcase
  end

  assign accept   = ref_edge && (st_reg.since >= MIN_GAP);
  assign missed   = !ref_edge && st_reg.have_ref && (st_reg.in_sel != IN_NONE)
                    && (st_reg.since >= MISS_GAP);
  // phase error: offset from the nearest second boundary
  assign err      = ({2'b00, st_reg.ns} >= HALF_NS) ? {2'b00, st_reg.ns} - SEC_NS
                                                    : {2'b00, st_reg.ns};
  assign err_abs  = mag(err);
  // frequency error: period deviation in ns per second, i.e. ppb
  assign ferr     = 32'((st_reg.since + 32'h1 - CYC_SEC) * CLK_NS);
  assign ferr_abs = mag(ferr);
  assign ns_inc   = {2'b00, st_reg.ns} + CLK_NS;

  // ==========================================================
  // next state
  always_comb
  begin
    st_next         = st_reg;
    st_next.rdata   = 32'h0000_0000;
    st_next.pulse_d = i_pulse;

    // free run from the crystal
    if (ns_inc >= SEC_NS)
    begin
      st_next.ns  = 30'(ns_inc - SEC_NS);
      st_next.sec = st_reg.sec + 32'h1;
    end
    else
    begin
      st_next.ns = 30'(ns_inc);
    end
    st_next.since = st_reg.since + 32'h1;

    // configuration writes
    if (wr_ctrl)
    begin
      case (i_bus.wdata[CTRL_IN_LSB +: 2])
        2'h1:    st_next.in_sel = IN_SERIAL;
        2'h2:    st_next.in_sel = IN_OVER;
        default: st_next.in_sel = IN_NONE;
      endcase
      st_next.out_sel = ptcs_out_t'(i_bus.wdata[CTRL_OUT_LSB +: 2]);
    end
    if (i_bus.wr && (i_bus.addr == OFS_THRESH))
    begin
      st_next.thresh = i_bus.wdata;
    end
    if (tick_over)
    begin
      st_next.host_sec = i_bus.wdata;
    end
    if (i_bus.wr && (i_bus.addr == OFS_HOST_NS))
    begin
      st_next.host_ns = i_bus.wdata[29:0];
    end

    // statistics clear first, so a same-cycle event still counts
    if (do_clear)
    begin
      st_next.total     = 32'h0;
      st_next.bad       = 32'h0;
      st_next.singles   = 32'h0;
      st_next.longest   = 32'h0;
      st_next.run       = 32'h0;
      st_next.fail      = 32'h0;
      st_next.resync    = 32'h0;
      st_next.freq_err  = 32'h0;
      st_next.phase_err = 32'h0;
      st_next.worst_f   = 32'h0;
      st_next.worst_p   = 32'h0;
    end

    // reference handling
    if (ref_edge && !accept)
    begin
      st_next.bad = st_next.bad + 32'h1;
    end
    if (accept)
    begin
      st_next.total     = st_next.total + 32'h1;
      st_next.run       = 32'h0;
      st_next.since     = 32'h0;
      st_next.phase_err = err;
      st_next.freq_err  = st_reg.have_ref ? ferr : 32'h0;
      if (err_abs > st_next.worst_p)
      begin
        st_next.worst_p = err_abs;
      end
      if (st_reg.have_ref && (ferr_abs > st_next.worst_f))
      begin
        st_next.worst_f = ferr_abs;
      end
      st_next.have_ref = 1'b1;
      // align to the second boundary
      st_next.ns  = 30'h0;
      st_next.sec = err[31] ? st_reg.sec + 32'h1 : st_reg.sec;
      if (err_abs > st_reg.thresh)
      begin
        st_next.fail   = st_next.fail + 32'h1;
        st_next.resync = st_next.resync + 32'h1;
        st_next.synced = 1'b0;
      end
      else
      begin
        st_next.synced = 1'b1;
      end
    end
    if (missed)
    begin
      st_next.singles = st_next.singles + 32'h1;
      st_next.run     = st_next.run + 32'h1;
      if (st_next.run > st_next.longest)
      begin
        st_next.longest = st_next.run;
      end
      st_next.since  = st_reg.since - CYC_SEC;
      st_next.synced = 1'b0;
    end
    if (st_reg.in_sel == IN_NONE)
    begin
      st_next.synced   = 1'b0;
      st_next.have_ref = 1'b0;
    end

    // host time commands; reset also restores the default selectors
    if (do_set || do_reset)
    begin
      st_next.sec = st_reg.host_sec;
      st_next.ns  = st_reg.host_ns;
    end
    if (do_reset)
    begin
      st_next.in_sel  = IN_SERIAL;
      st_next.out_sel = OUT_NONE;
    end

    // synchronisation output
    st_next.sync_oe_n = (st_reg.out_sel == OUT_NONE);
    case (st_reg.out_sel)
      OUT_REPEAT: st_next.sync_out = i_pulse;
      OUT_LOOP:
      begin
        case (st_reg.in_sel)
          IN_SERIAL: st_next.sync_out = i_pulse;
          IN_OVER:   st_next.sync_out = int_pulse;
          default:   st_next.sync_out = 1'b0;
        endcase
      end
      // master pulse works alongside host discipline for a slave card
      OUT_MASTER: st_next.sync_out = int_pulse;
      default:    st_next.sync_out = 1'b0;
    endcase

    // register reads, one cycle later
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        OFS_CTRL:     st_next.rdata = {28'h0, st_reg.out_sel, st_reg.in_sel};
        OFS_THRESH:   st_next.rdata = st_reg.thresh;
        OFS_HOST_SEC: st_next.rdata = st_reg.host_sec;
        OFS_HOST_NS:  st_next.rdata = {2'b00, st_reg.host_ns};
        OFS_STATUS:   st_next.rdata = {30'h0, st_reg.have_ref, st_reg.synced};
        OFS_TIME_SEC: st_next.rdata = st_reg.sec;
        OFS_TIME_NS:  st_next.rdata = {2'b00, st_reg.ns};
        OFS_TOTAL:    st_next.rdata = st_reg.total;
        OFS_BAD:      st_next.rdata = st_reg.bad;
        OFS_SINGLES:  st_next.rdata = st_reg.singles;
        OFS_LONGEST:  st_next.rdata = st_reg.longest;
        OFS_FAIL:     st_next.rdata = st_reg.fail;
        OFS_RESYNC:   st_next.rdata = st_reg.resync;
        OFS_FREQ:     st_next.rdata = st_reg.freq_err;
        OFS_PHASE:    st_next.rdata = st_reg.phase_err;
        OFS_WFREQ:    st_next.rdata = st_reg.worst_f;
        OFS_WPHASE:   st_next.rdata = st_reg.worst_p;
        default:      st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg           <= '0;
      st_reg.in_sel    <= IN_SERIAL;
      st_reg.out_sel   <= OUT_NONE;
      st_reg.thresh    <= THRESH_RST;
      st_reg.sync_oe_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_rdata     = st_reg.rdata;
  assign o_sync_out  = st_reg.sync_out;
  assign o_sync_oe_n = st_reg.sync_oe_n;
  assign o_synced    = st_reg.synced;

  // ==========================================================
  // checks
  chk_set_load: assert property (@(posedge i_clock) disable iff (!i_resetn)
    do_set && !do_reset && !wr_ctrl |=> st_reg.sec == $past(st_reg.host_sec)
      && st_reg.in_sel == $past(st_reg.in_sel) && st_reg.out_sel == $past(st_reg.out_sel))
    else $error("set command did not load host time");

  chk_full_reset: assert property (@(posedge i_clock) disable iff (!i_resetn)
    do_reset |=> st_reg.in_sel == IN_SERIAL && st_reg.out_sel == OUT_NONE
      && st_reg.ns == $past(st_reg.host_ns))
    else $error("full reset left wrong selectors");

  chk_out_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
    st_reg.out_sel == OUT_NONE |=> o_sync_oe_n && !o_sync_out)
    else $error("output driven while off");

  chk_repeat_out: assert property (@(posedge i_clock) disable iff (!i_resetn)
    st_reg.out_sel == OUT_REPEAT |=> !o_sync_oe_n && o_sync_out == $past(i_pulse))
    else $error("repeat output differs from input");

  chk_loop_out: assert property (@(posedge i_clock) disable iff (!i_resetn)
    st_reg.out_sel == OUT_LOOP && st_reg.in_sel == IN_SERIAL |=> o_sync_out == $past(i_pulse))
    else $error("loop output differs from selected input");

  chk_master_out: assert property (@(posedge i_clock) disable iff (!i_resetn)
    st_reg.out_sel == OUT_MASTER |=> o_sync_out == $past(int_pulse))
    else $error("master output is not the internal pulse");

  chk_no_source: assert property (@(posedge i_clock) disable iff (!i_resetn)
    st_reg.in_sel == IN_NONE && !wr_ctrl && !do_reset ##1 st_reg.in_sel == IN_NONE |=> !o_synced)
    else $error("synchronised with no input");

  chk_free_run: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !accept && !do_set && !do_reset && ns_inc < SEC_NS |=> st_reg.ns == 30'($past(ns_inc)))
    else $error("clock did not advance by one period");

  chk_fail_count: assert property (@(posedge i_clock) disable iff (!i_resetn)
    accept && !do_clear && err_abs > st_reg.thresh |=> st_reg.fail == $past(st_reg.fail) + 32'h1
      && !o_synced)
    else $error("failure not counted above threshold");

  chk_stats_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
    do_clear && !ref_edge && !missed |=> st_reg.total == 32'h0 && st_reg.bad == 32'h0)
    else $error("statistics not cleared");

  chk_bad_count: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ref_edge && !accept && !do_clear |=> st_reg.bad == $past(st_reg.bad) + 32'h1)
    else $error("early pulse not counted as bad");

  chk_miss_count: assert property (@(posedge i_clock) disable iff (!i_resetn)
    missed && !do_clear |=> st_reg.singles == $past(st_reg.singles) + 32'h1 && !o_synced)
    else $error("missed pulse not counted");

  chk_worst_phase: assert property (@(posedge i_clock) disable iff (!i_resetn)
    accept |=> st_reg.worst_p >= mag(st_reg.phase_err))
    else $error("worst phase below current error");

endmodule

// ===== test_pps_timestamp_clock_sync.sv
// self-checking bench of the timestamp clock unit through its register port
// assumes a shortened second of 1000 cycles and the pulse model on the serial input
`timescale 1ns/1ns
module test_pps_timestamp_clock_sync;
  import ptcs_pkg::*;
  // ==========================================================
  // settings and signals
  localparam logic [31:0] CYC = 32'h0000_03E8;  // cycles per shortened second
  localparam int NOM  = 32'h0000_03E8;  // nominal gap
  localparam int SLOW = 32'h0000_03F2;  // gap ten cycles longer than nominal
  localparam int MISS = 32'h0000_0640;  // gap that loses one pulse
  localparam int SHRT = 32'h0000_0064;  // gap too short to accept
  localparam logic [7:0] STATS [8] = '{OFS_TOTAL, OFS_BAD, OFS_SINGLES, OFS_LONGEST,
                                       OFS_FAIL, OFS_RESYNC, OFS_WFREQ, OFS_WPHASE};
  logic        i_clock;      // 25 MHz
  logic        i_resetn;     // active low
  ptcs_bus_t   bus;          // register port
  logic        pulse;        // serial pulse line
  logic [31:0] o_rdata;
  logic        o_sync_out;
  logic        o_sync_oe_n;
  logic        o_synced;
  logic        rep_on;       // output must echo the serial input
  logic        pulse_prev;   // serial input one cycle back
  logic [31:0] rv;           // read value
  int          err_total;
  int          cmp_count;

  ptcs_top #(.CYC_SEC(CYC)) ptcs_top_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_bus(bus),
    .i_pulse(pulse), .o_rdata(o_rdata), .o_sync_out(o_sync_out), .o_sync_oe_n(o_sync_oe_n),
    .o_synced(o_synced));
  ptcs_pulse_src ptcs_pulse_src_i (.i_clock(i_clock), .o_pulse(pulse));

  // ==========================================================
  // clock, 40 ns period
  initial i_clock = 1'b0;
  always #20 i_clock = ~i_clock;

  // ==========================================================
  // shared tasks
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clock);
    bus.wr <= 1'b0;
    @(posedge i_clock);
  endtask
  // read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge i_clock);
    bus.rd <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
    @(posedge i_clock);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // echo monitor: output follows the input with one cycle of latency
  always @(negedge i_clock)
  begin
    if (rep_on)
      check(32'(o_sync_out), 32'(pulse_prev));
    pulse_prev = pulse;
  end

  // watchdog, well beyond the 11.4k cycles the tests take
  initial
  begin
    repeat (60000) @(posedge i_clock);
    err_total++;
    print_verdict();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    i_resetn   = 1'b0;
    bus        = '0;
    rep_on     = 1'b0;
    pulse_prev = 1'b0;
    err_total  = 0;
    cmp_count  = 0;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    // defaults, unmapped and write-only places
    check(32'(o_sync_oe_n), 32'h0000_0001);
    check(32'(o_synced), 32'h0000_0000);
    rc(OFS_CTRL, 32'h0000_0001);
    rc(OFS_THRESH, THRESH_RST);
    rc(OFS_TOTAL, 32'h0000_0000);
    rc(OFS_CMD, 32'h0000_0000);
    wr(8'h80, 32'hFFFF_FFFF);
    rc(8'h80, 32'h0000_0000);
    rc(OFS_CTRL, 32'h0000_0001);
    $display("test defaults done");
    // serial discipline with a wide threshold, one interval ten cycles longer
    wr(OFS_THRESH, 32'h0010_0000);
    wr(OFS_CTRL, 32'h0000_0005);
    wr(OFS_HOST_SEC, 32'h0000_0005);
    wr(OFS_HOST_NS, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0001);
    rc(OFS_CTRL, 32'h0000_0005);
    rc(OFS_TIME_SEC, 32'h0000_0005);
    check(32'(o_sync_oe_n), 32'h0000_0000);
    // the first pulse must also keep the minimum gap, counted from reset
    repeat (NOM / 2) @(posedge i_clock);
    rep_on = 1'b1;
    ptcs_pulse_src_i.emit(NOM);
    ptcs_pulse_src_i.emit(NOM);
    ptcs_pulse_src_i.emit(SLOW);
    ptcs_pulse_src_i.emit(NOM);
    check(32'(o_synced), 32'h0000_0001);
    rc(OFS_STATUS, 32'h0000_0003);
    rc(OFS_TOTAL, 32'h0000_0004);
    rc(OFS_FREQ, 32'h0000_0190);
    rc(OFS_WFREQ, 32'h0000_0190);
    // last interval 1010 cycles: 1009 periods of 40 ns past the aligned second
    rc(OFS_PHASE, 32'h0000_9DA8);
    rc(OFS_WPHASE, 32'h0000_9DA8);
    rc(OFS_FAIL, 32'h0000_0000);
    $display("test serial discipline done");
    // default threshold is exceeded by a 40 us phase error
    wr(OFS_THRESH, THRESH_RST);
    ptcs_pulse_src_i.emit(NOM);
    check(32'(o_synced), 32'h0000_0000);
    rc(OFS_FAIL, 32'h0000_0001);
    rc(OFS_RESYNC, 32'h0000_0001);
    // one pulse missing, then one too early
    ptcs_pulse_src_i.emit(MISS);
    ptcs_pulse_src_i.emit(NOM);
    rc(OFS_SINGLES, 32'h0000_0001);
    rc(OFS_LONGEST, 32'h0000_0001);
    ptcs_pulse_src_i.emit(SHRT);
    ptcs_pulse_src_i.emit(NOM);
    rc(OFS_BAD, 32'h0000_0001);
    rep_on = 1'b0;
    wr(OFS_CMD, 32'h0000_0004);
    foreach (STATS[i]) rc(STATS[i], 32'h0000_0000);
    $display("test statistics done");
    // loop output with the serial input selected
    wr(OFS_CTRL, 32'h0000_0009);
    rep_on = 1'b1;
    ptcs_pulse_src_i.emit(NOM);
    rep_on = 1'b0;
    $display("test loop serial done");
    // no source: free run, not synchronised, output off
    wr(OFS_CTRL, 32'h0000_0000);
    @(posedge i_clock);
    check(32'(o_synced), 32'h0000_0000);
    check(32'(o_sync_oe_n), 32'h0000_0001);
    rc(OFS_STATUS, 32'h0000_0000);
    rd(OFS_TIME_NS, rv);
    repeat (98) @(posedge i_clock);
    rc(OFS_TIME_NS, rv + 32'h0000_0FA0);
    $display("test free run done");
    // host-time source with master output, then loop of that source
    wr(OFS_CTRL, 32'h0000_000E);
    wr(OFS_HOST_SEC, 32'h0000_0006);
    repeat (NOM) @(posedge i_clock);
    wr(OFS_HOST_SEC, 32'h0000_0007);
    rd(OFS_STATUS, rv);
    check(rv & 32'h0000_0002, 32'h0000_0002);
    check(32'(o_sync_oe_n), 32'h0000_0000);
    check(32'(o_sync_out), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_000A);
    check(32'(o_sync_out), 32'h0000_0001);
    // move the clock past the pulse width: the internal pulse must drop
    wr(OFS_HOST_NS, PULSE_NS);
    wr(OFS_CMD, 32'h0000_0001);
    @(posedge i_clock);
    check(32'(o_sync_out), 32'h0000_0000);
    $display("test master done");
    // full reset command
    wr(OFS_CTRL, 32'h0000_0008);
    wr(OFS_HOST_SEC, 32'h0000_0009);
    wr(OFS_HOST_NS, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0002);
    rc(OFS_CTRL, 32'h0000_0001);
    rc(OFS_TIME_SEC, 32'h0000_0009);
    rc(OFS_THRESH, THRESH_RST);
    check(32'(o_sync_oe_n), 32'h0000_0001);
    $display("test full reset done");
    print_verdict();
  end
endmodule
